// file: hdl/acc_top.sv
// Control logic around the analog comparator, with its AXI4-Lite register slave.
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "acc_params.svh"
module acc_top
	import acc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cmpRaw,
	input wire logic irqVectorAck,
	output acc_ana_ctrl_t anaCtrl_r,
	output logic captureOut_r,
	output logic irqReq_r
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations.

	acc_bus_state_t wrState_r;
	acc_bus_state_t rdState_r;
	logic [7:0] sfr_r;
	logic cmpDisable_r;
	logic bandgap_r;
	logic irqFlag_r;
	logic irqEnable_r;
	logic captureEn_r;
	logic [1:0] irqMode_r;
	logic convEnable_r;
	logic [2:0] chanSel_r;
	logic globalIe_r;
	logic compResult;
	logic edgeEvent;
	logic wrFire;
	logic rdFire;
	logic wrLow;
	logic flagClear;
	logic [7:0] ccrView;
	logic [31:0] readWord;

	// Decode shared by the read and the write channel.
	function automatic logic isMapped(input logic [3:0] addr);
		isMapped = (addr == `ACC_SFR_ADDR) || (addr == `ACC_CCR_ADDR) || (addr == `ACC_EXT_ADDR);
	endfunction : isMapped

	////////////////////////////////////////////////////////////////////////////////
	// Comparator output path.

	// The analog stage drives cmpRaw high while the chosen positive input is above the negative one.
	acc_sync_edge u_sync (
		.clk_sys(clk_sys),
		.reset(reset),
		.rawIn(cmpRaw),
		.irqMode(irqMode_r),
		.syncOut(compResult),
		.edgeEvent(edgeEvent)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Write channel.

	// Address and data are taken together, so a write never half-lands.
	assign wrFire = s_axi_awready & s_axi_awvalid & s_axi_wvalid;
	// Only byte lane zero carries register bits; other lanes are ignored.
	assign wrLow = wrFire & s_axi_wstrb[0];

	// Write handshake sequencer.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			wrState_r <= ACC_IDLE;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `ACC_RESP_OKAY;
		end
		else
		begin
			case (wrState_r)
				ACC_IDLE:
				begin
					if (s_axi_awvalid && s_axi_wvalid)
					begin
						s_axi_awready <= 1'b1;
						s_axi_wready <= 1'b1;
						wrState_r <= ACC_TAKE;
					end
				end
				ACC_TAKE:
				begin
					if (wrFire)
					begin
						s_axi_awready <= 1'b0;
						s_axi_wready <= 1'b0;
						s_axi_bvalid <= 1'b1;
						s_axi_bresp <= isMapped(s_axi_awaddr) ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
						wrState_r <= ACC_RESP;
					end
				end
				ACC_RESP:
				begin
					if (s_axi_bready)
					begin
						s_axi_bvalid <= 1'b0;
						wrState_r <= ACC_IDLE;
					end
				end
				default:
				begin
					s_axi_awready <= 1'b0;
					s_axi_wready <= 1'b0;
					s_axi_bvalid <= 1'b0;
					wrState_r <= ACC_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers written by software.

	// Special function register; bit 4 is read-only zero and never stored.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			sfr_r <= `ACC_SFR_RESET;
		else if (wrLow && s_axi_awaddr == `ACC_SFR_ADDR)
		begin
			sfr_r <= s_axi_wdata[7:0];
			sfr_r[`ACC_SFR_RO_BIT] <= 1'b0;
		end
	end

	// Comparator control fields; mode and disable changes are not guarded here, software must mask first.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			cmpDisable_r <= 1'b0;
			bandgap_r <= 1'b0;
			irqEnable_r <= 1'b0;
			captureEn_r <= 1'b0;
			irqMode_r <= `ACC_MODE_TOGGLE;
		end
		else if (wrLow && s_axi_awaddr == `ACC_CCR_ADDR)
		begin
			cmpDisable_r <= s_axi_wdata[`ACC_CCR_DIS_BIT];
			bandgap_r <= s_axi_wdata[`ACC_CCR_BG_BIT];
			irqEnable_r <= s_axi_wdata[`ACC_CCR_IE_BIT];
			captureEn_r <= s_axi_wdata[`ACC_CCR_CAP_BIT];
			irqMode_r <= s_axi_wdata[1:0];
		end
	end

	// Converter enable, channel select and processor global enable, mirrored here.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			convEnable_r <= 1'b0;
			chanSel_r <= 3'h0;
			globalIe_r <= 1'b0;
		end
		else if (wrLow && s_axi_awaddr == `ACC_EXT_ADDR)
		begin
			convEnable_r <= s_axi_wdata[`ACC_EXT_CEN_BIT];
			chanSel_r <= s_axi_wdata[`ACC_EXT_CH_LSB +: 3];
			globalIe_r <= s_axi_wdata[`ACC_EXT_GIE_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt flag and request.

	// Clear by a one written to the flag, or by the vector being taken.
	assign flagClear = (wrLow && s_axi_awaddr == `ACC_CCR_ADDR && s_axi_wdata[`ACC_CCR_FLAG_BIT])
		|| irqVectorAck;

	// A new event in the clearing cycle wins, so no edge is ever lost.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			irqFlag_r <= 1'b0;
		else if (edgeEvent)
			irqFlag_r <= 1'b1;
		else if (flagClear)
			irqFlag_r <= 1'b0;
	end

	// The request follows the flag one cycle later, gated by both enables.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			irqReq_r <= 1'b0;
		else
			irqReq_r <= irqFlag_r & irqEnable_r & globalIe_r;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Analog stage controls and capture route.

	// Negative input goes to the channel mux only while the converter leaves it free.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			anaCtrl_r <= '0;
		else
		begin
			anaCtrl_r.powerDown <= cmpDisable_r;
			anaCtrl_r.bandgapSel <= bandgap_r;
			anaCtrl_r.negMuxSel <= sfr_r[`ACC_SFR_MUXEN_BIT] & ~convEnable_r;
			anaCtrl_r.negChannel <= chanSel_r;
		end
	end

	// Synchronised result goes to the timer front end; its noise canceller does the filtering.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			captureOut_r <= 1'b0;
		else
			captureOut_r <= captureEn_r & compResult;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read channel.

	// Comparator control view with the live synchronised result.
	assign ccrView = {cmpDisable_r, bandgap_r, compResult, irqFlag_r,
		irqEnable_r, captureEn_r, irqMode_r};

	// Read multiplexer; unmapped words read as zero.
	always_comb
	begin
		readWord = 32'h0000_0000;
		case (s_axi_araddr)
			`ACC_SFR_ADDR: readWord[7:0] = sfr_r;
			`ACC_CCR_ADDR: readWord[7:0] = ccrView;
			`ACC_EXT_ADDR: readWord[4:0] = {globalIe_r, chanSel_r, convEnable_r};
			default: readWord = 32'h0000_0000;
		endcase
	end

	assign rdFire = s_axi_arready & s_axi_arvalid;

	// Read handshake sequencer.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			rdState_r <= ACC_IDLE;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `ACC_RESP_OKAY;
		end
		else
		begin
			case (rdState_r)
				ACC_IDLE:
				begin
					if (s_axi_arvalid)
					begin
						s_axi_arready <= 1'b1;
						rdState_r <= ACC_TAKE;
					end
				end
				ACC_TAKE:
				begin
					if (rdFire)
					begin
						s_axi_arready <= 1'b0;
						s_axi_rvalid <= 1'b1;
						s_axi_rdata <= readWord;
						s_axi_rresp <= isMapped(s_axi_araddr) ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
						rdState_r <= ACC_RESP;
					end
				end
				ACC_RESP:
				begin
					if (s_axi_rready)
					begin
						s_axi_rvalid <= 1'b0;
						rdState_r <= ACC_IDLE;
					end
				end
				default:
				begin
					s_axi_arready <= 1'b0;
					s_axi_rvalid <= 1'b0;
					rdState_r <= ACC_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions and covers.

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	property p_flag_set;
		edgeEvent |=> irqFlag_r;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("event did not set flag");

	property p_ack_clear;
		(irqVectorAck && !edgeEvent) |=> !irqFlag_r;
	endproperty
	a_ack_clear: assert property (p_ack_clear) else $error("vector did not clear flag");

	property p_w1c;
		(wrLow && s_axi_awaddr == `ACC_CCR_ADDR && s_axi_wdata[4] && !edgeEvent) |=> !irqFlag_r;
	endproperty
	a_w1c: assert property (p_w1c) else $error("write one did not clear flag");

	property p_w0_keep;
		(irqFlag_r && !irqVectorAck && !(wrLow && s_axi_awaddr == `ACC_CCR_ADDR && s_axi_wdata[4]))
			|=> irqFlag_r;
	endproperty
	a_w0_keep: assert property (p_w0_keep) else $error("flag lost without clear");

	property p_irq_gate;
		irqReq_r |-> $past(irqFlag_r) && $past(irqEnable_r) && $past(globalIe_r);
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("request without enables");

	property p_neg_mux;
		(wrLow && s_axi_awaddr == `ACC_SFR_ADDR && s_axi_wdata[3] && !convEnable_r)
			|-> ##2 anaCtrl_r.negMuxSel;
	endproperty
	a_neg_mux: assert property (p_neg_mux) else $error("mux not selected");

	property p_neg_pin;
		anaCtrl_r.negMuxSel |-> $past(sfr_r[3]) && !$past(convEnable_r);
	endproperty
	a_neg_pin: assert property (p_neg_pin) else $error("mux used while not allowed");

	property p_power;
		(wrLow && s_axi_awaddr == `ACC_CCR_ADDR) |-> ##2 (anaCtrl_r.powerDown == $past(s_axi_wdata[7], 2));
	endproperty
	a_power: assert property (p_power) else $error("power down not applied");

	property p_sfr_ro;
		!sfr_r[4];
	endproperty
	a_sfr_ro: assert property (p_sfr_ro) else $error("read-only bit stored");

	property p_capture;
		captureOut_r |-> $past(captureEn_r) && $past(compResult);
	endproperty
	a_capture: assert property (p_capture) else $error("capture route while off");

	property p_bvalid_hold;
		(s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid;
	endproperty
	a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");

	c_flag_set: cover property (edgeEvent ##1 irqFlag_r);
	c_irq_req: cover property (irqReq_r);
	c_set_wins: cover property (edgeEvent && flagClear);
	c_capture: cover property (captureOut_r);

endmodule : acc_top

// file: hdl/acc_params.svh
// Offsets, field positions, reset values and codes of the analog comparator control block.
// Behaviour
// - Result high when positive input exceeds negative
// - Mux on, converter off: channel picks pin
// - Otherwise negative input is dedicated pin
// - Mux enable is bit 3; bit 4 reads zero
// - Disable bit 7 powers comparator down
// - Bandgap bit 6 replaces positive input
// - Output synchronised, one to two cycles late
// - Flag bit 4 set on matching event
// - Flag cleared when interrupt vector executes
// - Write one clears flag, zero keeps
// - Request needs enable bit and global enable
// - Capture bit 2 routes output to timer
// - Mode: toggle, reserved, falling, rising
// - Converter enable frees or claims the mux
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH

// Register byte addresses on the AXI4-Lite bus.
`define ACC_SFR_ADDR 4'h0
`define ACC_CCR_ADDR 4'h4
`define ACC_EXT_ADDR 4'h8

// Special function register fields.
`define ACC_SFR_RO_BIT 4
`define ACC_SFR_MUXEN_BIT 3
`define ACC_SFR_RESET 8'h00

// Comparator control register fields.
`define ACC_CCR_DIS_BIT 7
`define ACC_CCR_BG_BIT 6
`define ACC_CCR_OUT_BIT 5
`define ACC_CCR_FLAG_BIT 4
`define ACC_CCR_IE_BIT 3
`define ACC_CCR_CAP_BIT 2
`define ACC_CCR_RESET 8'h00

// Converter and processor side register fields.
`define ACC_EXT_CEN_BIT 0
`define ACC_EXT_CH_LSB 1
`define ACC_EXT_GIE_BIT 4

// Interrupt mode codes.
`define ACC_MODE_TOGGLE 2'h0
`define ACC_MODE_RESERVED 2'h1
`define ACC_MODE_FALL 2'h2
`define ACC_MODE_RISE 2'h3

// AXI response codes.
`define ACC_RESP_OKAY 2'h0
`define ACC_RESP_SLVERR 2'h2

`endif

// file: hdl/acc_pkg.sv
// Types shared by the analog comparator control block.
package acc_pkg;

	// Controls handed to the analog comparator stage.
	typedef struct packed {
		logic powerDown;
		logic bandgapSel;
		logic negMuxSel;
		logic [2:0] negChannel;
	} acc_ana_ctrl_t;

	// Bus slave channel states.
	typedef enum logic [1:0] {ACC_IDLE, ACC_TAKE, ACC_RESP} acc_bus_state_t;

endpackage : acc_pkg

// file: hdl/acc_sync_edge.sv
// Synchroniser and edge detector for the raw comparator output.
`timescale 1ns/1ps
`include "acc_params.svh"
module acc_sync_edge
	import acc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic rawIn,
	input wire logic [1:0] irqMode,
	output logic syncOut,
	output logic edgeEvent
);
	logic meta_r;
	logic prev_r;
	logic [1:0] settle_r;

	// Two flops; only the second one is looked at by anything else.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			meta_r <= 1'b0;
			syncOut <= 1'b0;
		end
		else
		begin
			meta_r <= rawIn;
			syncOut <= meta_r;
		end
	end

	// Previous synchronised value, kept for edge detection.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			prev_r <= 1'b0;
		else
			prev_r <= syncOut;
	end

	// Mode decode; the reserved code yields no event so stray writes stay silent.
	always_comb
	begin
		case (irqMode)
			`ACC_MODE_TOGGLE: edgeEvent = syncOut ^ prev_r;
			`ACC_MODE_FALL: edgeEvent = ~syncOut & prev_r;
			`ACC_MODE_RISE: edgeEvent = syncOut & ~prev_r;
			default: edgeEvent = 1'b0;
		endcase
	end

	// Settling counter so the delay check never looks back into reset.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			settle_r <= 2'h0;
		else if (settle_r != 2'h3)
			settle_r <= settle_r + 2'h1;
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	property p_sync_delay;
		(settle_r == 2'h3) |-> (syncOut == $past(rawIn, 2));
	endproperty
	a_sync_delay: assert property (p_sync_delay) else $error("sync delay wrong");

	property p_rise_only;
		(edgeEvent && irqMode == `ACC_MODE_RISE) |-> (syncOut && !$past(syncOut));
	endproperty
	a_rise_only: assert property (p_rise_only) else $error("rise event without rise");

	property p_fall_only;
		(edgeEvent && irqMode == `ACC_MODE_FALL) |-> (!syncOut && $past(syncOut));
	endproperty
	a_fall_only: assert property (p_fall_only) else $error("fall event without fall");

	property p_reserved_quiet;
		(irqMode == `ACC_MODE_RESERVED) |-> !edgeEvent;
	endproperty
	a_reserved_quiet: assert property (p_reserved_quiet) else $error("event in reserved mode");

endmodule : acc_sync_edge

// file: verification/acc_analog_model.sv
// Behavioural analog comparator stage and timer capture front end.
`timescale 1ns/1ps
module acc_analog_model
	import acc_pkg::*;
#(
	parameter int BANDGAP_LEVEL = 12
)
(
	input wire logic clk_sys,
	input wire acc_ana_ctrl_t anaCtrl,
	input wire logic captureIn,
	input wire logic timerCapIe,
	input var int posV,
	input var int negV,
	input var int chanV[8],
	output logic cmpRaw,
	output int capCount
);
	int selPos;
	int selNeg;
	int capCnt = 0;
	logic capPrev = 1'b0;
	////////////////////////////////////////////////////////////////
	// Input selection and compare; a powered-down stage reads low.
	always_comb
	begin
		selPos = anaCtrl.bandgapSel ? BANDGAP_LEVEL : posV;
		selNeg = anaCtrl.negMuxSel ? chanV[anaCtrl.negChannel] : negV;
		cmpRaw = !anaCtrl.powerDown && (selPos > selNeg);
	end
	////////////////////////////////////////////////////////////////
	// Capture edges count only while the timer's own enable is set.
	always_ff @(posedge clk_sys)
	begin
		capPrev <= captureIn;
		if (captureIn && !capPrev && timerCapIe)
			capCnt <= capCnt + 1;
	end
	assign capCount = capCnt;
endmodule : acc_analog_model

// file: verification/test_analog_comparator_control.sv
// Self-checking bench for the analog comparator control block.
`timescale 1ns/1ps
`include "acc_params.svh"
module test_analog_comparator_control
	import acc_pkg::*;
;
	logic clk_sys, reset, awValid, awReady, wValid, wReady, bValid, bReady;
	logic arValid, arReady, rValid, rReady, cmpRaw, vecAck, capOut, irqReq;
	logic [3:0] awAddr, arAddr, wStrb;
	logic [31:0] wData, rData;
	logic [1:0] bResp, rResp;
	acc_ana_ctrl_t anaCtrl;
	int posV, negV, capCount, num_errors, tests_run;
	int chanV[8];
	acc_top u_acc_top (.clk_sys(clk_sys), .reset(reset), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
		.s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
		.s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
		.s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .cmpRaw(cmpRaw),
		.irqVectorAck(vecAck), .anaCtrl_r(anaCtrl), .captureOut_r(capOut), .irqReq_r(irqReq));
	acc_analog_model u_acc_analog_model (.clk_sys(clk_sys), .anaCtrl(anaCtrl), .captureIn(capOut),
		.timerCapIe(1'b1), .posV(posV), .negV(negV), .chanV(chanV), .cmpRaw(cmpRaw), .capCount(capCount));
	////////////////////////////////////////////////////////////////
	// Shared helpers.
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick
	// Address and data are offered together and held until the slave takes them.
	task automatic wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
		@(posedge clk_sys);
		awAddr <= a;
		wData <= {24'h000000, d};
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		do @(posedge clk_sys); while (awReady !== 1'b1);
		awValid <= 1'b0;
		wValid <= 1'b0;
		do @(posedge clk_sys); while (bValid !== 1'b1);
		r = bResp;
		bReady <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys);
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		do @(posedge clk_sys); while (arReady !== 1'b1);
		arValid <= 1'b0;
		do @(posedge clk_sys); while (rValid !== 1'b1);
		d = rData;
		r = rResp;
		rReady <= 1'b0;
	endtask : rd
	////////////////////////////////////////////////////////////////
	// Reset values, the read-only bit and an unmapped word.
	task automatic testRegs;
		logic [31:0] d;
		logic [1:0] r;
		rd(`ACC_SFR_ADDR, d, r);
		check(d, 32'h00000000);
		rd(`ACC_CCR_ADDR, d, r);
		check(d, 32'h00000000);
		wr(`ACC_SFR_ADDR, 8'hFF, r);
		rd(`ACC_SFR_ADDR, d, r);
		check(d, 32'h000000EF);
		wr(`ACC_SFR_ADDR, 8'h00, r);
		// A write without byte lane zero must leave the register alone but still answer OKAY.
		wStrb <= 4'hE;
		wr(`ACC_SFR_ADDR, 8'hFF, r);
		wStrb <= 4'hF;
		check(32'(r), 32'(`ACC_RESP_OKAY));
		rd(`ACC_SFR_ADDR, d, r);
		check(d, 32'h00000000);
		wr(4'hC, 8'hFF, r);
		check(32'(r), 32'(`ACC_RESP_SLVERR));
		rd(4'hC, d, r);
		check({d[29:0], r}, 32'(`ACC_RESP_SLVERR));
		$display("registers test done");
	endtask : testRegs
	////////////////////////////////////////////////////////////////
	// Every channel in turn, then the converter reclaims the mux.
	task automatic testMux;
		logic [31:0] d;
		logic [1:0] r;
		posV <= 5;
		wr(`ACC_SFR_ADDR, 8'h08, r);
		for (int i = 0; i < 8; i++)
		begin
			wr(`ACC_EXT_ADDR, 8'(i << 1), r);
			tick(4);
			rd(`ACC_CCR_ADDR, d, r);
			check(32'(d[5]), 32'(5 > 2 * i));
		end
		// Channel seven stays selected, so only the dedicated pin can make the result high.
		posV <= 12;
		wr(`ACC_EXT_ADDR, 8'h0F, r);
		tick(4);
		rd(`ACC_CCR_ADDR, d, r);
		check(32'(d[5]), 32'h1);
		wr(`ACC_EXT_ADDR, 8'h00, r);
		wr(`ACC_SFR_ADDR, 8'h00, r);
		// Bandgap beats the dedicated negative pin, power-down forces low.
		posV <= 0;
		wr(`ACC_CCR_ADDR, 8'h40, r);
		tick(4);
		rd(`ACC_CCR_ADDR, d, r);
		check(32'({d[5], anaCtrl.bandgapSel}), 32'h3);
		wr(`ACC_CCR_ADDR, 8'hC0, r); // Interrupt stays off here.
		tick(4);
		rd(`ACC_CCR_ADDR, d, r);
		check(32'({d[5], anaCtrl.powerDown}), 32'h1);
		wr(`ACC_CCR_ADDR, 8'h00, r);
		$display("input select test done");
	endtask : testMux
	////////////////////////////////////////////////////////////////
	// All four edge modes against a rise and a fall.
	task automatic testModes;
		logic [31:0] d;
		logic [1:0] r;
		for (int m = 0; m < 4; m++)
		begin
			wr(`ACC_CCR_ADDR, 8'(8'h10 | m), r); // Enable is off while the mode moves.
			posV <= 20;
			tick(4);
			rd(`ACC_CCR_ADDR, d, r);
			check(32'(d[4]), 32'(m == 0 || m == 3));
			wr(`ACC_CCR_ADDR, 8'(8'h10 | m), r);
			posV <= 0;
			tick(4);
			rd(`ACC_CCR_ADDR, d, r);
			check(32'(d[4]), 32'(m == 0 || m == 2));
		end
		$display("edge mode test done");
	endtask : testModes
	////////////////////////////////////////////////////////////////
	// Request gating, clears, and the capture route.
	task automatic testIrq;
		logic [31:0] d;
		logic [1:0] r;
		wr(`ACC_CCR_ADDR, 8'h1B, r);
		posV <= 20;
		tick(4);
		rd(`ACC_CCR_ADDR, d, r);
		check(32'({d[4], irqReq}), 32'h2);
		wr(`ACC_CCR_ADDR, 8'h0B, r);
		rd(`ACC_CCR_ADDR, d, r);
		check(32'(d[4]), 32'h1);
		wr(`ACC_EXT_ADDR, 8'h10, r);
		tick(3);
		check(32'(irqReq), 32'h1);
		vecAck <= 1'b1;
		@(posedge clk_sys);
		vecAck <= 1'b0;
		tick(3);
		rd(`ACC_CCR_ADDR, d, r);
		check(32'({d[4], irqReq}), 32'h0);
		wr(`ACC_CCR_ADDR, 8'h13, r);
		posV <= 0;
		wr(`ACC_CCR_ADDR, 8'h17, r);
		tick(4);
		posV <= 20;
		// The timer model counts one edge after the route output rises, so wait one cycle more.
		tick(5);
		check(32'(capOut), 32'h1);
		check(32'(capCount), 32'h1);
		wr(`ACC_CCR_ADDR, 8'h13, r);
		tick(3);
		check(32'(capOut), 32'h0);
		$display("interrupt and capture test done");
	endtask : testIrq
	////////////////////////////////////////////////////////////////
	// Verdict and end of run.
	task automatic report_and_stop;
		$display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop
	// Clock of 40 ns period.
	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// Watchdog: the tests need well under a thousand cycles.
	initial
	begin
		repeat (5000) @(posedge clk_sys);
		num_errors++;
		report_and_stop();
	end
	// Main sequence.
	initial
	begin
		{reset, awValid, wValid, bReady, arValid, rReady, vecAck} = 7'h40;
		{awAddr, arAddr, wData, wStrb} = {8'h00, 32'h00000000, 4'hF};
		{posV, negV, num_errors, tests_run} = {32'd0, 32'd9, 64'd0};
		for (int i = 0; i < 8; i++)
			chanV[i] = 2 * i;
		repeat (8) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		testRegs();
		testMux();
		testModes();
		testIrq();
		report_and_stop();
	end
endmodule : test_analog_comparator_control
